// file: core/ts0mx_cfg.svh
/*
 Constants of the timeslot-zero inserter and stream multiplexer.
 Assumes it is included by bare name before the package and modules.
*/
`ifndef TS0MX_CFG_SVH
`define TS0MX_CFG_SVH

// ****************************************************************
// Frame word layout
// ****************************************************************
`define TS0MX_ALIGN_WORD 7'h1B
`define TS0MX_NONSYNC_BIT2 1'h1
`define TS0MX_BIT_FIRST 4'h1
`define TS0MX_BIT_TAIL 4'h2
`define TS0MX_BIT_LAST 4'h8
`define TS0MX_USER_LO 3
`define TS0MX_USER_HI 8
`define TS0MX_TAIL_MSB 6

// ****************************************************************
// Reset values and pin bundle
// ****************************************************************
`define TS0MX_SYNC_RST 1'h1
`define TS0MX_PIN_COUNT 11

`endif

// file: core/ts0mx_pkg.sv
/*
 Types of the timeslot-zero inserter and stream multiplexer.
 Assumes the constants header is on the include path.
*/
`include "ts0mx_cfg.svh"

package ts0mx_pkg;
   // Generator state: waiting for a window or sending the slot
   typedef enum logic {TS0MX_IDLE, TS0MX_SLOT} ts0mx_state_t;
   // Bit number inside a timeslot
   typedef logic [3:0] ts0mx_bit_t;
   // Bits 2 to 8 of timeslot zero, bit 2 in the top position
   typedef logic [`TS0MX_TAIL_MSB:0] ts0mx_tail_t;
endpackage

// file: core/ts0mx_sync_if.sv
/*
 Carrier between the top and its pin synchroniser.
 Assumes raw pins from outside the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface ts0mx_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] stable;
   modport sync (input raw, output stable);
   modport user (output raw, input stable);
endinterface

`default_nettype wire

// file: core/ts0mx_sync.sv
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes one core clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module ts0mx_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   ts0mx_sync_if.sync pins
);
   import ts0mx_pkg::*;

   logic [W-1:0] meta_ff, s2_ff, s3_ff, stable_ff;
   logic [W-1:0] nxt_stable;

   // Refuse a bundle with no pins
   generate
      if (W < 1) begin : g_bad_width
         $error("ts0mx_sync width must be at least one");
      end
   endgenerate

   // ****************************************************************
   // Filter
   // ****************************************************************
   // Take a bit only once stages two and three agree
   always_comb begin
      nxt_stable = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & stable_ff);
   end

   // Stage registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         stable_ff <= '0;
      end else begin
         meta_ff <= pins.raw;
         s2_ff <= meta_ff;
         s3_ff <= s2_ff;
         stable_ff <= nxt_stable;
      end
   end

   assign pins.stable = stable_ff;

   // Disagreeing stages keep the old value
   a_filter_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s2_ff == ~s3_ff) |=> stable_ff == $past(stable_ff))
      else $error("filter took a bit before stages agreed");
endmodule

`default_nettype wire

// file: core/ts0_insert_and_tx_mux.sv
/*
 Timeslot-zero word builder and output stream multiplexer.
 Assumes every input other than core_clk and rst_n is a pin from upstream framing logic,
 including the 2.048 MHz bit clock, all sampled on the 100 MHz core clock.
*/
// Behaviour
// R1: In non-sync frames user bit input n is sent as bit n, n from 3 to 8.
// R2: Upstream holds the user bits stable before the edge that ends bit 1.
// R3: The stream carries the built slot in timeslot zero, channel data else.
// R4: Upstream drives the window high for exactly eight bit periods.
// R5: The window is sampled on the falling edge of the bit clock.
// R6: Bit 1 appears as soon as the window rises, with no bit clock edge.
// R7: The window is the multiplexer select, high choosing the built slot.
// R8: Bits 2 to 8 advance on rising bit clock edges, bit 1 on the window.
// R9: Bits count 1 to 8, timeslots 0 to 31, frames 0 to 15.
// R10: Sync frames carry the alignment word in bits 2 to 8, alternating.
// R11: Non-sync frames force bit 2 to one.
// R12: Bit 1 is the sync or non-sync international bit by frame type.
// R13: The sync flag is high in sync slots and moves one period after.
// R14: Frame type toggles once per window and starts at a reset value.
`timescale 1ns/1ps
`default_nettype none
`include "ts0mx_cfg.svh"

module ts0_insert_and_tx_mux (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pcm_clk_in,
   input wire logic ts0_window_in,
   input wire logic chan_data_in,
   input wire logic sync_intl_bit_in,
   input wire logic nonsync_intl_bit_in,
   input wire logic [`TS0MX_USER_HI:`TS0MX_USER_LO] user_bits_in,
   output logic mux_stream_out,
   output logic sync_frame_flag_out
);
   import ts0mx_pkg::*;

   // ****************************************************************
   // Pin synchronisation
   // ****************************************************************
   ts0mx_sync_if #(.W(`TS0MX_PIN_COUNT)) pin_if ();

   logic clk_s, win_s, data_s, intl_sync_s, intl_non_s;
   logic [`TS0MX_USER_HI:`TS0MX_USER_LO] user_s;

   // Bundle pins in, unpack filtered values
   assign pin_if.raw = {pcm_clk_in, ts0_window_in, chan_data_in,
                        sync_intl_bit_in, nonsync_intl_bit_in, user_bits_in};
   assign {clk_s, win_s, data_s, intl_sync_s, intl_non_s, user_s} =
          pin_if.stable;

   ts0mx_sync #(.W(`TS0MX_PIN_COUNT)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pins(pin_if.sync)
   );

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   logic clk_prev_ff, win_prev_ff;
   logic pcm_rise, pcm_fall, win_rise;

   // Edges of the filtered bit clock and window
   always_comb begin
      pcm_rise = clk_s & ~clk_prev_ff;
      pcm_fall = ~clk_s & clk_prev_ff;
      win_rise = win_s & ~win_prev_ff;
   end

   // Previous filtered levels
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev_ff <= 1'h0;
         win_prev_ff <= 1'h0;
      end else begin
         clk_prev_ff <= clk_s;
         win_prev_ff <= win_s;
      end
   end

   // ****************************************************************
   // Frame type tracking
   // ****************************************************************
   logic win_fall_ff, seen_ff, sync_ff;
   logic nxt_win_fall, nxt_seen, nxt_sync;

   // Window sample, pulse memory and sync/non-sync toggle
   always_comb begin
      nxt_win_fall = win_fall_ff;
      nxt_seen = seen_ff;
      nxt_sync = sync_ff;
      if (pcm_fall) begin
         nxt_win_fall = win_s; // R5
      end
      if (pcm_rise) begin
         if (win_fall_ff) begin
            nxt_seen = 1'h1;
         end else if (seen_ff) begin
            nxt_seen = 1'h0;
            nxt_sync = ~sync_ff; // R13 R14 R10
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_fall_ff <= 1'h0;
         seen_ff <= 1'h0;
         sync_ff <= `TS0MX_SYNC_RST; // R14
      end else begin
         win_fall_ff <= nxt_win_fall;
         seen_ff <= nxt_seen;
         sync_ff <= nxt_sync;
      end
   end

   // ****************************************************************
   // Slot generator and multiplexer
   // ****************************************************************
   ts0mx_state_t st_ff, nxt_st;
   ts0mx_bit_t cnt_ff, nxt_cnt;
   ts0mx_tail_t shift_ff, nxt_shift, tail;
   logic out_ff, nxt_out, gen_bit, gen_ff, nxt_gen;

   // Bits 2 to 8 for the current frame type
   always_comb begin
      tail = `TS0MX_ALIGN_WORD; // R10
      if (!sync_ff) begin
         tail[`TS0MX_TAIL_MSB] = `TS0MX_NONSYNC_BIT2; // R11
         for (int i = `TS0MX_USER_LO; i <= `TS0MX_USER_HI; i++) begin
            tail[`TS0MX_USER_HI - i] = user_s[i]; // R1 R2
         end
      end
   end

   // Bit sequencing: bit 1 on the window, bits 2 to 8 on the clock
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      gen_bit = gen_ff;
      case (st_ff)
         TS0MX_IDLE: begin
            if (win_rise) begin
               nxt_st = TS0MX_SLOT;
               nxt_cnt = `TS0MX_BIT_FIRST; // R9
               gen_bit = sync_ff ? intl_sync_s : intl_non_s; // R6 R12
            end
         end
         TS0MX_SLOT: begin
            if (!win_s) begin
               nxt_st = TS0MX_IDLE; // R4
            end else if (pcm_rise && cnt_ff != `TS0MX_BIT_LAST) begin
               nxt_cnt = cnt_ff + `TS0MX_BIT_FIRST; // R8 R9
               if (cnt_ff == `TS0MX_BIT_FIRST) begin
                  gen_bit = tail[`TS0MX_TAIL_MSB];
                  nxt_shift = {tail[`TS0MX_TAIL_MSB-1:0], 1'h0};
               end else begin
                  gen_bit = shift_ff[`TS0MX_TAIL_MSB];
                  nxt_shift = {shift_ff[`TS0MX_TAIL_MSB-1:0], 1'h0};
               end
            end
         end
         default: begin
            nxt_st = TS0MX_IDLE;
         end
      endcase
      nxt_gen = gen_bit;
      nxt_out = win_s ? gen_bit : data_s; // R3 R7
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= TS0MX_IDLE;
         cnt_ff <= `TS0MX_BIT_FIRST;
         shift_ff <= '0;
         gen_ff <= 1'h0;
         out_ff <= 1'h0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         gen_ff <= nxt_gen;
         out_ff <= nxt_out;
      end
   end

   // Outputs straight from registers
   assign mux_stream_out = out_ff;
   assign sync_frame_flag_out = sync_ff;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic tail_edge;
   assign tail_edge = st_ff == TS0MX_SLOT && win_s && pcm_rise &&
                      cnt_ff == `TS0MX_BIT_FIRST;

   a_channel_pass: assert property ( // R3 R7
      !win_s |=> out_ff == $past(data_s))
      else $error("channel data not passed outside the slot");
   a_bit1_at_window: assert property ( // R6 R12
      (st_ff == TS0MX_IDLE && win_rise) |=>
      out_ff == ($past(sync_ff) ? $past(intl_sync_s) : $past(intl_non_s)))
      else $error("bit 1 not sent on window rise");
   a_align_bit2: assert property ( // R10
      (tail_edge && sync_ff) |=> !out_ff ##0 shift_ff[`TS0MX_TAIL_MSB] == 1'h0)
      else $error("alignment word bits 2 and 3 wrong");
   a_nonsync_bit2: assert property ( // R11
      (tail_edge && !sync_ff) |=> out_ff)
      else $error("bit 2 not forced high in non-sync frame");
   a_user_bit3: assert property ( // R1
      (tail_edge && !sync_ff) |=>
      shift_ff[`TS0MX_TAIL_MSB] == $past(user_s[`TS0MX_USER_LO]))
      else $error("user bit 3 not placed");
   a_window_sample: assert property ( // R5
      pcm_fall |=> win_fall_ff == $past(win_s))
      else $error("window not sampled on falling clock edge");
   a_count_hold: assert property ( // R8
      (st_ff == TS0MX_SLOT && win_s && !pcm_rise) |=> $stable(cnt_ff))
      else $error("bit advanced without a rising clock edge");
   a_frame_toggle: assert property ( // R13 R14
      (pcm_rise && !win_fall_ff && seen_ff) |=>
      sync_frame_flag_out != $past(sync_frame_flag_out))
      else $error("frame type did not toggle after the slot");
   a_flag_steady: assert property ( // R13
      (win_s && win_fall_ff) |=> $stable(sync_frame_flag_out))
      else $error("sync flag moved inside the slot");

   c_sync_slot: cover property (tail_edge && sync_ff);
   c_nonsync_slot: cover property (tail_edge && !sync_ff);
   c_toggle: cover property (pcm_rise && !win_fall_ff && seen_ff);
   c_last_bit: cover property (st_ff == TS0MX_SLOT &&
                               cnt_ff == `TS0MX_BIT_LAST);
endmodule

`default_nettype wire

// file: verif/ts0mx_upstream_model.sv
/*
 Upstream framing model: bit clock, timeslot-zero window, channel data.
 Assumes a 1 ns time unit and a free-running 2.048 MHz bit clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ts0mx_upstream_model #(
   parameter int HALF_NS = 244
) (
   output logic pcm_clk_in,
   output logic ts0_window_in,
   output logic chan_data_in,
   input wire logic [7:0] chan_pat
);
   // ****************************************************************
   // Frame timing
   // ****************************************************************
   int bit_idx;
   int slot_idx;

   // Pins move 50 ns after each bit clock rise, away from both edges
   initial begin
      pcm_clk_in = 1'h0;
      ts0_window_in = 1'h0;
      chan_data_in = 1'h0;
      bit_idx = 0;
      slot_idx = 30;
      #3.3;
      forever begin
         #(HALF_NS) pcm_clk_in = 1'h1;
         #50;
         bit_idx = (bit_idx + 1) % 8;
         if (bit_idx == 0) begin
            slot_idx = (slot_idx + 1) % 32;
         end
         ts0_window_in = (slot_idx == 0);
         chan_data_in = chan_pat[bit_idx];
         #(HALF_NS - 50) pcm_clk_in = 1'h0;
      end
   end
endmodule

`default_nettype wire

// file: verif/ts0_insert_and_tx_mux_tb.sv
/*
 Self-checking bench of the timeslot-zero inserter and stream multiplexer.
 Assumes the upstream model drives bit clock, window and channel data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ts0mx_cfg.svh"

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("FAIL %0t ns: got %b expected %b", $time, g, e); end end

module ts0_insert_and_tx_mux_tb;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic core_clk, rst_n, sync_intl, nonsync_intl;
   logic [`TS0MX_USER_HI:`TS0MX_USER_LO] user;
   logic [7:0] chan_pat;
   logic pcm_clk_in, ts0_window_in, chan_data_in;
   logic mux_stream_out, sync_frame_flag_out;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   ts0mx_upstream_model up (.pcm_clk_in(pcm_clk_in),
      .ts0_window_in(ts0_window_in), .chan_data_in(chan_data_in),
      .chan_pat(chan_pat));

   ts0_insert_and_tx_mux dut (.core_clk(core_clk), .rst_n(rst_n),
      .pcm_clk_in(pcm_clk_in), .ts0_window_in(ts0_window_in),
      .chan_data_in(chan_data_in), .sync_intl_bit_in(sync_intl),
      .nonsync_intl_bit_in(nonsync_intl), .user_bits_in(user),
      .mux_stream_out(mux_stream_out),
      .sync_frame_flag_out(sync_frame_flag_out));

   // Core clock and hang guard
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 70000) begin
         fail_count++;
         close_out();
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Frame data set well before the window, after the last slot ended
   task automatic set_pins(input logic s, input logic n,
      input logic [5:0] u, input logic [7:0] p);
      @(posedge core_clk);
      #1;
      sync_intl = s;
      nonsync_intl = n;
      user = u;
      chan_pat = p;
   endtask

   // Walks one slot bit by bit, then the channel bit and flag move
   task automatic check_slot(input logic exp_sync);
      logic [7:0] w;
      w = exp_sync ? {sync_intl, `TS0MX_ALIGN_WORD} :
         {nonsync_intl, `TS0MX_NONSYNC_BIT2, user[3], user[4], user[5],
          user[6], user[7], user[8]};
      @(posedge ts0_window_in);
      #100;
      `CHK(mux_stream_out, w[7])
      for (int j = 1; j <= 8; j++) begin
         @(negedge pcm_clk_in);
         #1;
         `CHK(mux_stream_out, w[8 - j])
         `CHK(sync_frame_flag_out, exp_sync)
      end
      @(negedge pcm_clk_in);
      #1;
      `CHK(mux_stream_out, chan_data_in)
      `CHK(sync_frame_flag_out, exp_sync)
      @(negedge pcm_clk_in);
      #1;
      `CHK(sync_frame_flag_out, ~exp_sync)
   endtask

   // Channel timeslots pass the serial data straight through
   task automatic chk_chan();
      for (int k = 0; k < 200; k++) begin
         @(negedge pcm_clk_in);
         #1;
         if (ts0_window_in === 1'h0) begin
            `CHK(mux_stream_out, chan_data_in)
         end
      end
   endtask

   // Reset in mid-frame restarts with a sync frame
   task automatic pulse_reset();
      @(posedge core_clk);
      #1;
      rst_n = 1'h0;
      repeat (5) @(posedge core_clk);
      #1;
      `CHK(sync_frame_flag_out, `TS0MX_SYNC_RST)
      `CHK(mux_stream_out, 1'h0)
      rst_n = 1'h1;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst_n = 1'h0;
      sync_intl = 1'h0;
      nonsync_intl = 1'h0;
      user = 6'h00;
      chan_pat = 8'h00;
      repeat (5) @(posedge core_clk);
      #1;
      rst_n = 1'h1;
      set_pins(1'h1, 1'h0, 6'h00, 8'h35);
      check_slot(1'h1);
      set_pins(1'h1, 1'h0, 6'h00, 8'hA5);
      check_slot(1'h0);
      set_pins(1'h0, 1'h1, 6'h3F, 8'hC3);
      check_slot(1'h1);
      chk_chan();
      pulse_reset();
      set_pins(1'h1, 1'h0, 6'h2D, 8'h5A);
      check_slot(1'h1);
      // Lopsided user pattern so a reversed bit order shows
      set_pins(1'h0, 1'h1, 6'h0E, 8'h3C);
      check_slot(1'h0);
      close_out();
   end
endmodule

`default_nettype wire
